// ---- rtl/reset_source_pkg.sv ----
// Constants and carrier types for the reset-source bookkeeping block.
// Assumes a single 100 MHz core clock and an APB register port.
`default_nettype none
package reset_source_pkg;
	// Clock
	localparam int CLK_PERIOD_NS = 10;
	// Register byte offsets on APB
	localparam logic [7:0] ADDR_FILTER_WIDTH = 8'h00;
	localparam logic [7:0] ADDR_CAUSE_FLAGS = 8'h04;
	localparam logic [7:0] ADDR_PROG_CTRL_ONE = 8'h08;
	localparam logic [7:0] ADDR_CORE_STATUS = 8'h0C;
	localparam logic [7:0] ADDR_IRQ_STATUS = 8'h10;
	localparam logic [7:0] ADDR_IRQ_MASK = 8'h14;
	// Reset values
	localparam logic [1:0] FILTER_WIDTH_RST = 2'h1;
	localparam logic [3:0] CAUSE_FLAGS_RST = 4'h0;
	localparam logic [7:0] PROG_CTRL_RST = 8'h00;
	localparam logic [6:0] IRQ_RST = 7'h00;
	localparam logic [2:0] PIN_STABLE_RST = 3'h4;
	// Cause flag positions
	localparam int CAUSE_RCTRL_BIT = 3;
	localparam int CAUSE_BROWNOUT_BIT = 2;
	localparam int CAUSE_CFGERR_BIT = 1;
	localparam int CAUSE_WDTCFG_BIT = 0;
	// Core status positions
	localparam int STAT_TIMEOUT_BIT = 5;
	localparam int STAT_POWERDOWN_BIT = 4;
	// Pin indices into the synchroniser bank
	localparam int PIN_BROWNOUT_LOW = 0;
	localparam int PIN_SLOW_OSC = 1;
	localparam int PIN_EXT_RESET = 2;
	localparam int PIN_COUNT = 3;
	// Brown-out filter widths in slow oscillator ticks
	localparam logic [7:0] FILTER_TICKS_00 = 8'h08;
	localparam logic [7:0] FILTER_TICKS_01 = 8'h20;
	localparam logic [7:0] FILTER_TICKS_10 = 8'h40;
	localparam logic [7:0] FILTER_TICKS_11 = 8'h80;
	// Codes
	localparam logic [7:0] PROG_RESET_KEY = 8'h55;
	localparam logic [7:0] RCTRL_IO_CODE = 8'h55;
	localparam logic [7:0] RCTRL_PIN_CODE = 8'hAA;
	localparam logic [7:0] LEVEL_CODE_A = 8'h66;
	localparam logic [7:0] LEVEL_CODE_B = 8'h55;
	localparam logic [7:0] LEVEL_CODE_C = 8'h33;
	localparam logic [7:0] LEVEL_CODE_D = 8'h99;
	localparam logic [7:0] LEVEL_CODE_E = 8'hAA;
	localparam logic [7:0] LEVEL_DISABLE = 8'hF0;
	// Initialisation actions sent to the core
	typedef struct packed {
		logic clear_pc;
		logic clear_sp;
		logic clear_ptrs;
		logic clear_intc;
		logic port_ones;
		logic clear_wdt_tb;
		logic timers_off;
	} init_actions_type;
	localparam init_actions_type INIT_FULL = 7'h7F;
	localparam init_actions_type INIT_WARM = 7'h60;
	localparam init_actions_type INIT_NONE = 7'h00;
	// Reset events, one sticky interrupt bit each
	typedef struct packed {
		logic ext_pin;
		logic wdt_sleep;
		logic wdt_normal;
		logic prog_key;
		logic rctrl_illegal;
		logic level_illegal;
		logic brownout;
	} reset_events_type;
endpackage
`default_nettype wire

// ---- rtl/reset_source_flags_and_init.sv ----
// Reset-source bookkeeping: brown-out filter, cause flags, init actions.
// Assumes i_rst_n is the power-on reset and the core applies o_init.
//
// The placing of the registers and the APB interface to the registers were decided locally.
`default_nettype none
module reset_source_flags_and_init (
	// Clock and power-on reset
	input wire logic i_core_clk,
	input wire logic i_rst_n,
	// APB slave
	input wire logic i_psel,
	input wire logic i_penable,
	input wire logic i_pwrite,
	input wire logic [7:0] i_paddr,
	input wire logic [31:0] i_pwdata,
	output logic o_pready,
	output logic [31:0] o_prdata,
	output logic o_pslverr,
	// Pins from outside the clock domain
	input wire logic i_brownout_low,
	input wire logic i_slow_osc_clk,
	input wire logic i_ext_reset_pin_n,
	// Core-side inputs on the same clock
	input wire logic i_sleep_mode,
	input wire logic i_wdt_timeout,
	input wire logic i_wdt_cfg_error,
	input wire logic [7:0] i_brownout_level_select,
	input wire logic [7:0] i_reset_pin_function_ctrl,
	// Outputs to the core
	output logic o_device_reset,
	output reset_source_pkg::init_actions_type o_init,
	output logic o_timeout_status_flag,
	output logic o_powerdown_status_flag,
	output logic [1:0] o_filter_width_code,
	// Interrupt
	output logic o_irq
);

	////////////////////////////////////////////////////////////////////////
	// Declarations

	logic [reset_source_pkg::PIN_COUNT-1:0] pin_raw;
	logic [reset_source_pkg::PIN_COUNT-1:0] sync1_q;
	logic [reset_source_pkg::PIN_COUNT-1:0] sync2_q;
	logic [reset_source_pkg::PIN_COUNT-1:0] sync3_q;
	logic [reset_source_pkg::PIN_COUNT-1:0] stable_q;
	logic [reset_source_pkg::PIN_COUNT-1:0] stable_d;
	logic [reset_source_pkg::PIN_COUNT-1:0] stable_prev_q;
	logic slow_tick;
	logic ext_fall;
	logic brownout_low;
	logic [1:0] filter_width_code_q;
	logic [3:0] cause_flags_q;
	logic [3:0] cause_flags_d;
	logic [3:0] cause_set;
	logic [3:0] cause_clr;
	logic [7:0] prog_ctrl_q;
	logic [6:0] irq_status_q;
	logic [6:0] irq_status_d;
	logic [6:0] irq_mask_q;
	logic [6:0] irq_clr;
	logic [7:0] filter_cnt_q;
	logic filter_done_q;
	logic [7:0] filter_limit;
	logic brownout_enabled;
	logic brownout_fire;
	logic level_illegal;
	logic level_illegal_q;
	logic rctrl_illegal;
	logic rctrl_illegal_q;
	logic ext_pin_selected;
	logic por_pending_q;
	logic full_reset;
	logic apb_setup;
	logic apb_access;
	logic wr_en;
	logic addr_mapped;
	logic [31:0] rd_data;
	logic pready_q;
	logic [31:0] prdata_q;
	logic pslverr_q;
	logic device_reset_q;
	reset_source_pkg::init_actions_type init_q;
	logic timeout_q;
	logic powerdown_q;
	logic irq_q;
	reset_source_pkg::reset_events_type events;

	////////////////////////////////////////////////////////////////////////
	// Pin synchronisers: three stages, a change counts when 2 and 3 agree

	assign pin_raw[reset_source_pkg::PIN_BROWNOUT_LOW] = i_brownout_low;
	assign pin_raw[reset_source_pkg::PIN_SLOW_OSC] = i_slow_osc_clk;
	assign pin_raw[reset_source_pkg::PIN_EXT_RESET] = i_ext_reset_pin_n;

	genvar gi;
	generate
		for (gi = 0; gi < reset_source_pkg::PIN_COUNT; gi++) begin : g_sync
			assign stable_d[gi] = (sync2_q[gi] == sync3_q[gi]) ?
				sync3_q[gi] : stable_q[gi];
			always_ff @(posedge i_core_clk) begin
				if (!i_rst_n) begin
					sync1_q[gi] <= reset_source_pkg::PIN_STABLE_RST[gi];
					sync2_q[gi] <= reset_source_pkg::PIN_STABLE_RST[gi];
					sync3_q[gi] <= reset_source_pkg::PIN_STABLE_RST[gi];
					stable_q[gi] <= reset_source_pkg::PIN_STABLE_RST[gi];
					stable_prev_q[gi] <= reset_source_pkg::PIN_STABLE_RST[gi];
				end else begin
					sync1_q[gi] <= pin_raw[gi];
					sync2_q[gi] <= sync1_q[gi];
					sync3_q[gi] <= sync2_q[gi];
					stable_q[gi] <= stable_d[gi];
					stable_prev_q[gi] <= stable_q[gi];
				end
			end
		end
	endgenerate

	assign brownout_low = stable_q[reset_source_pkg::PIN_BROWNOUT_LOW];
	assign slow_tick = stable_q[reset_source_pkg::PIN_SLOW_OSC] &
		!stable_prev_q[reset_source_pkg::PIN_SLOW_OSC];
	// The pin only resets when the reset-control value selects it
	assign ext_pin_selected =
		(i_reset_pin_function_ctrl == reset_source_pkg::RCTRL_PIN_CODE);
	assign ext_fall = ext_pin_selected &
		stable_prev_q[reset_source_pkg::PIN_EXT_RESET] &
		!stable_q[reset_source_pkg::PIN_EXT_RESET];

	////////////////////////////////////////////////////////////////////////
	// Configuration checks

	always_comb begin
		case (i_brownout_level_select)
			reset_source_pkg::LEVEL_CODE_A,
			reset_source_pkg::LEVEL_CODE_B,
			reset_source_pkg::LEVEL_CODE_C,
			reset_source_pkg::LEVEL_CODE_D,
			reset_source_pkg::LEVEL_CODE_E,
			reset_source_pkg::LEVEL_DISABLE: level_illegal = 1'b0;
			default: level_illegal = 1'b1;
		endcase
	end

	assign rctrl_illegal =
		(i_reset_pin_function_ctrl != reset_source_pkg::RCTRL_IO_CODE) &&
		(i_reset_pin_function_ctrl != reset_source_pkg::RCTRL_PIN_CODE);

	// Edge detect so a stuck illegal value resets once, not every cycle
	always_ff @(posedge i_core_clk) begin
		if (!i_rst_n) begin
			level_illegal_q <= 1'b0;
			rctrl_illegal_q <= 1'b0;
		end else begin
			level_illegal_q <= level_illegal;
			rctrl_illegal_q <= rctrl_illegal;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Brown-out filter

	// Tick phase is unknown at assertion, so N ticks span N-1 to N periods
	always_comb begin
		case (filter_width_code_q)
			2'h0: filter_limit = reset_source_pkg::FILTER_TICKS_00;
			2'h1: filter_limit = reset_source_pkg::FILTER_TICKS_01;
			2'h2: filter_limit = reset_source_pkg::FILTER_TICKS_10;
			default: filter_limit = reset_source_pkg::FILTER_TICKS_11;
		endcase
	end

	// Detector is off in sleep, when disabled, or on a bad level code
	assign brownout_enabled = !i_sleep_mode && !level_illegal &&
		(i_brownout_level_select != reset_source_pkg::LEVEL_DISABLE);

	assign brownout_fire = brownout_enabled && brownout_low && slow_tick &&
		!filter_done_q && (filter_cnt_q == filter_limit - 8'h01);

	always_ff @(posedge i_core_clk) begin
		if (!i_rst_n) begin
			filter_cnt_q <= 8'h00;
			filter_done_q <= 1'b0;
		end else if (!(brownout_enabled && brownout_low)) begin
			filter_cnt_q <= 8'h00;
			filter_done_q <= 1'b0;
		end else if (brownout_fire) begin
			filter_cnt_q <= 8'h00;
			filter_done_q <= 1'b1;
		end else if (slow_tick && !filter_done_q) begin
			filter_cnt_q <= filter_cnt_q + 8'h01;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Reset events

	assign events.brownout = brownout_fire;
	assign events.level_illegal = level_illegal && !level_illegal_q;
	assign events.rctrl_illegal = rctrl_illegal && !rctrl_illegal_q;
	assign events.prog_key = wr_en &&
		(i_paddr == reset_source_pkg::ADDR_PROG_CTRL_ONE) &&
		(i_pwdata[7:0] == reset_source_pkg::PROG_RESET_KEY);
	assign events.wdt_normal = i_wdt_timeout && !i_sleep_mode;
	assign events.wdt_sleep = i_wdt_timeout && i_sleep_mode;
	assign events.ext_pin = ext_fall;

	// Any reset other than the sleep watchdog one reloads the full state
	assign full_reset = por_pending_q || events.brownout ||
		events.level_illegal || events.rctrl_illegal || events.prog_key ||
		events.wdt_normal || events.ext_pin || i_wdt_cfg_error;

	always_ff @(posedge i_core_clk) begin
		if (!i_rst_n) begin
			por_pending_q <= 1'b1;
		end else begin
			por_pending_q <= 1'b0;
		end
	end

	always_ff @(posedge i_core_clk) begin
		if (!i_rst_n) begin
			device_reset_q <= 1'b0;
		end else begin
			device_reset_q <= (full_reset && !por_pending_q) ||
				events.wdt_sleep;
		end
	end

	// Power-on shows the full set during reset and one cycle after release
	always_ff @(posedge i_core_clk) begin
		if (!i_rst_n) begin
			init_q <= reset_source_pkg::INIT_FULL;
		end else if (full_reset) begin
			init_q <= reset_source_pkg::INIT_FULL;
		end else if (events.wdt_sleep) begin
			init_q <= reset_source_pkg::INIT_WARM;
		end else begin
			init_q <= reset_source_pkg::INIT_NONE;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Time-out and power-down status

	always_ff @(posedge i_core_clk) begin
		if (!i_rst_n) begin
			timeout_q <= 1'b0;
			powerdown_q <= 1'b0;
		end else if (events.wdt_sleep) begin
			timeout_q <= 1'b1;
			powerdown_q <= 1'b1;
		end else if (events.wdt_normal) begin
			timeout_q <= 1'b1;
		end else if (events.ext_pin && i_sleep_mode) begin
			timeout_q <= 1'b0;
			powerdown_q <= 1'b1;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// APB slave, no wait states: pready rises in the first access cycle

	assign apb_setup = i_psel && !i_penable;
	assign apb_access = i_psel && i_penable && pready_q;
	assign wr_en = apb_access && i_pwrite && !pslverr_q;

	always_comb begin
		addr_mapped = 1'b1;
		rd_data = 32'h0000_0000;
		case (i_paddr)
			reset_source_pkg::ADDR_FILTER_WIDTH:
				rd_data[1:0] = filter_width_code_q;
			reset_source_pkg::ADDR_CAUSE_FLAGS:
				rd_data[3:0] = cause_flags_q;
			reset_source_pkg::ADDR_PROG_CTRL_ONE:
				rd_data[7:0] = prog_ctrl_q;
			reset_source_pkg::ADDR_CORE_STATUS: begin
				rd_data[reset_source_pkg::STAT_TIMEOUT_BIT] = timeout_q;
				rd_data[reset_source_pkg::STAT_POWERDOWN_BIT] = powerdown_q;
			end
			reset_source_pkg::ADDR_IRQ_STATUS:
				rd_data[6:0] = irq_status_q;
			reset_source_pkg::ADDR_IRQ_MASK:
				rd_data[6:0] = irq_mask_q;
			default:
				addr_mapped = 1'b0;
		endcase
	end

	always_ff @(posedge i_core_clk) begin
		if (!i_rst_n) begin
			pready_q <= 1'b0;
			prdata_q <= 32'h0000_0000;
			pslverr_q <= 1'b0;
		end else begin
			pready_q <= apb_setup;
			if (apb_setup) begin
				prdata_q <= i_pwrite ? 32'h0000_0000 : rd_data;
				pslverr_q <= !addr_mapped;
			end else if (!i_psel) begin
				prdata_q <= 32'h0000_0000;
				pslverr_q <= 1'b0;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Software registers; power-on is their only reset, except program-control-one, which also clears on the key reset

	always_ff @(posedge i_core_clk) begin
		if (!i_rst_n) begin
			filter_width_code_q <= reset_source_pkg::FILTER_WIDTH_RST;
		end else if (wr_en &&
			(i_paddr == reset_source_pkg::ADDR_FILTER_WIDTH)) begin
			filter_width_code_q <= i_pwdata[1:0];
		end
	end

	// Program-control-one clears after firing so a read shows it disarmed
	always_ff @(posedge i_core_clk) begin
		if (!i_rst_n) begin
			prog_ctrl_q <= reset_source_pkg::PROG_CTRL_RST;
		end else if (events.prog_key) begin
			prog_ctrl_q <= reset_source_pkg::PROG_CTRL_RST;
		end else if (wr_en &&
			(i_paddr == reset_source_pkg::ADDR_PROG_CTRL_ONE)) begin
			prog_ctrl_q <= i_pwdata[7:0];
		end
	end

	// Cause flags: a write of zero clears, hardware only sets; set wins
	always_comb begin
		cause_set = 4'h0;
		cause_set[reset_source_pkg::CAUSE_RCTRL_BIT] =
			events.rctrl_illegal;
		cause_set[reset_source_pkg::CAUSE_BROWNOUT_BIT] =
			events.brownout;
		cause_set[reset_source_pkg::CAUSE_CFGERR_BIT] =
			events.level_illegal;
		cause_set[reset_source_pkg::CAUSE_WDTCFG_BIT] = i_wdt_cfg_error;
		cause_clr = 4'h0;
		if (wr_en && (i_paddr == reset_source_pkg::ADDR_CAUSE_FLAGS)) begin
			cause_clr = ~i_pwdata[3:0];
		end
		cause_flags_d = (cause_flags_q & ~cause_clr) | cause_set;
	end

	always_ff @(posedge i_core_clk) begin
		if (!i_rst_n) begin
			cause_flags_q <= reset_source_pkg::CAUSE_FLAGS_RST;
		end else begin
			cause_flags_q <= cause_flags_d;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Interrupts: sticky status, write one to clear, set wins

	always_comb begin
		irq_clr = 7'h00;
		if (wr_en && (i_paddr == reset_source_pkg::ADDR_IRQ_STATUS)) begin
			irq_clr = i_pwdata[6:0];
		end
		irq_status_d = (irq_status_q & ~irq_clr) | events;
	end

	always_ff @(posedge i_core_clk) begin
		if (!i_rst_n) begin
			irq_status_q <= reset_source_pkg::IRQ_RST;
		end else begin
			irq_status_q <= irq_status_d;
		end
	end

	always_ff @(posedge i_core_clk) begin
		if (!i_rst_n) begin
			irq_mask_q <= reset_source_pkg::IRQ_RST;
		end else if (wr_en && (i_paddr == reset_source_pkg::ADDR_IRQ_MASK)) begin
			irq_mask_q <= i_pwdata[6:0];
		end
	end

	always_ff @(posedge i_core_clk) begin
		if (!i_rst_n) begin
			irq_q <= 1'b0;
		end else begin
			irq_q <= |(irq_status_d & irq_mask_q);
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Outputs

	assign o_pready = pready_q;
	assign o_prdata = prdata_q;
	assign o_pslverr = pslverr_q;
	assign o_device_reset = device_reset_q;
	assign o_init = init_q;
	assign o_timeout_status_flag = timeout_q;
	assign o_powerdown_status_flag = powerdown_q;
	assign o_filter_width_code = filter_width_code_q;
	assign o_irq = irq_q;

endmodule // reset_source_flags_and_init
`default_nettype wire

// ---- verif/reset_source_flags_and_init_monitor.sv ----
// Concurrent checks on the reset-source bookkeeping block's ports.
// Assumes one core clock and the synchronous active-low power-on reset.
`default_nettype none
module reset_source_flags_and_init_monitor (
	// Clock and reset
	input wire logic i_core_clk,
	input wire logic i_rst_n,
	// APB
	input wire logic i_psel,
	input wire logic i_penable,
	input wire logic i_pwrite,
	input wire logic [7:0] i_paddr,
	input wire logic [31:0] i_pwdata,
	input wire logic o_pready,
	input wire logic [31:0] o_prdata,
	// Core side
	input wire logic i_sleep_mode,
	input wire logic i_wdt_timeout,
	input wire logic o_device_reset,
	input wire reset_source_pkg::init_actions_type o_init,
	input wire logic o_timeout_status_flag,
	input wire logic o_powerdown_status_flag,
	input wire logic [1:0] o_filter_width_code
);
	default clocking @(posedge i_core_clk); endclocking
	default disable iff (!i_rst_n);
	////////////////////////////////////////////////////////////////////////
	sequence s_access;
		i_psel && i_penable && o_pready;
	endsequence
	sequence s_key_write;
		s_access ##0 (i_pwrite && i_paddr == reset_source_pkg::ADDR_PROG_CTRL_ONE
			&& i_pwdata[7:0] == reset_source_pkg::PROG_RESET_KEY);
	endsequence
	sequence s_read(logic [7:0] a);
		s_access ##0 (!i_pwrite && i_paddr == a);
	endsequence
	////////////////////////////////////////////////////////////////////////
	property p_pready;
		i_psel && !i_penable |=> o_pready;
	endproperty
	a_pready: assert property (p_pready) else $error("no ready after setup");
	property p_filter_read;
		s_read(reset_source_pkg::ADDR_FILTER_WIDTH) |->
			o_prdata == {30'h0, o_filter_width_code};
	endproperty
	a_filter_read: assert property (p_filter_read)
		else $error("filter width read wrong");
	property p_cause_read;
		s_read(reset_source_pkg::ADDR_CAUSE_FLAGS) |-> o_prdata[31:4] == 28'h0;
	endproperty
	a_cause_read: assert property (p_cause_read)
		else $error("cause flags upper bits not zero");
	property p_prog_key;
		s_key_write |-> ##[1:3]
			(o_device_reset && o_init == reset_source_pkg::INIT_FULL);
	endproperty
	a_prog_key: assert property (p_prog_key)
		else $error("key write gave no full reset");
	property p_wdt_normal;
		i_wdt_timeout && !i_sleep_mode |=> o_device_reset
			&& o_timeout_status_flag && o_init == reset_source_pkg::INIT_FULL;
	endproperty
	a_wdt_normal: assert property (p_wdt_normal)
		else $error("normal watchdog reset wrong");
	property p_wdt_sleep;
		i_wdt_timeout && i_sleep_mode |=> o_device_reset
			&& o_timeout_status_flag && o_powerdown_status_flag;
	endproperty
	a_wdt_sleep: assert property (p_wdt_sleep)
		else $error("sleep watchdog reset wrong");
	property p_to_cause;
		$rose(o_timeout_status_flag) |-> $past(i_wdt_timeout);
	endproperty
	a_to_cause: assert property (p_to_cause)
		else $error("time-out flag set without watchdog");
	property p_pd_cause;
		$rose(o_powerdown_status_flag) |-> $past(i_sleep_mode);
	endproperty
	a_pd_cause: assert property (p_pd_cause)
		else $error("power-down flag set outside sleep");
	property p_por;
		$rose(i_rst_n) |-> o_init == reset_source_pkg::INIT_FULL
			&& o_filter_width_code == reset_source_pkg::FILTER_WIDTH_RST
			&& !o_timeout_status_flag && !o_powerdown_status_flag;
	endproperty
	a_por: assert property (p_por)
		else $error("power-on state wrong");
endmodule // reset_source_flags_and_init_monitor
bind reset_source_flags_and_init reset_source_flags_and_init_monitor mon_u (
	.i_core_clk(i_core_clk),
	.i_rst_n(i_rst_n),
	.i_psel(i_psel),
	.i_penable(i_penable),
	.i_pwrite(i_pwrite),
	.i_paddr(i_paddr),
	.i_pwdata(i_pwdata),
	.o_pready(o_pready),
	.o_prdata(o_prdata),
	.i_sleep_mode(i_sleep_mode),
	.i_wdt_timeout(i_wdt_timeout),
	.o_device_reset(o_device_reset),
	.o_init(o_init),
	.o_timeout_status_flag(o_timeout_status_flag),
	.o_powerdown_status_flag(o_powerdown_status_flag),
	.o_filter_width_code(o_filter_width_code)
);
`default_nettype wire

// ---- verif/tb_reset_source_flags_and_init.sv ----
// Self-checking bench for the reset-source bookkeeping block.
// Assumes the monitor is bound; drives APB and event pins directly.
`default_nettype none
module tb_reset_source_flags_and_init;
	timeunit 1ns;
	timeprecision 1ns;
	logic clk, rst_n, psel, penable, pwrite, pready, pslverr, low, osc, pin_n;
	logic sleep, wdt, wdt_cfg, dev_rst, irq, to_f, pd_f;
	logic [7:0] paddr, level, rctrl;
	logic [31:0] pwdata, prdata;
	logic [1:0] wcode;
	reset_source_pkg::init_actions_type init, last_init;
	int errors = 0, cmp_count = 0, rst_count = 0, b;
	int ticks[4] = '{8, 32, 64, 128};
	////////////////////////////////////////////////////////////////////////
	reset_source_flags_and_init dut_u (
		.i_core_clk(clk), .i_rst_n(rst_n), .i_psel(psel),
		.i_penable(penable), .i_pwrite(pwrite), .i_paddr(paddr),
		.i_pwdata(pwdata), .o_pready(pready), .o_prdata(prdata),
		.o_pslverr(pslverr), .i_brownout_low(low), .i_slow_osc_clk(osc),
		.i_ext_reset_pin_n(pin_n), .i_sleep_mode(sleep),
		.i_wdt_timeout(wdt), .i_wdt_cfg_error(wdt_cfg),
		.i_brownout_level_select(level), .i_reset_pin_function_ctrl(rctrl),
		.o_device_reset(dev_rst), .o_init(init),
		.o_timeout_status_flag(to_f), .o_powerdown_status_flag(pd_f),
		.o_filter_width_code(wcode), .o_irq(irq)
	);
	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end
	// Reset pulses are one cycle wide, so count them where they land
	always @(posedge clk) begin
		if (dev_rst === 1'b1) begin
			rst_count <= rst_count + 1;
			last_init <= init;
		end
	end
	////////////////////////////////////////////////////////////////////////
	task automatic results();
		$display("errors %0d comparisons %0d", errors, cmp_count);
		if (errors == 0 && cmp_count > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask
	task automatic chk(input string n, input logic [31:0] e,
		input logic [31:0] g);
		cmp_count++;
		if (g !== e) begin
			$display("CHECK FAILED %s expected %h seen %h", n, e, g);
			errors++;
		end
	endtask
	task automatic bus(input logic w, input logic [7:0] a,
		input logic [31:0] d, output logic [31:0] r, output logic e);
		int n;
		n = 0;
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		penable <= 1'b1;
		@(posedge clk);
		while (pready !== 1'b1 && n < 16) begin
			@(posedge clk);
			n++;
		end
		r = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		// One idle edge keeps psel from being assigned twice in a step
		@(posedge clk);
		// A second edge lets outputs registered off the access settle
		@(posedge clk);
		if (n >= 16) begin
			errors++;
			results();
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		logic [31:0] r;
		logic e;
		bus(1'b1, a, d, r, e);
	endtask
	task automatic rd(input string n, input logic [7:0] a,
		input logic [31:0] x);
		logic [31:0] r;
		logic e;
		bus(1'b0, a, 32'h0, r, e);
		chk(n, x, r);
	endtask
	task automatic tick(input int n);
		repeat (n) begin
			osc <= 1'b1;
			repeat (5) @(posedge clk);
			osc <= 1'b0;
			repeat (5) @(posedge clk);
		end
	endtask
	task automatic dip(input int n, input int x);
		int s;
		s = rst_count;
		low <= 1'b1;
		tick(n);
		low <= 1'b0;
		repeat (8) @(posedge clk);
		chk("brownout resets", 32'(s + x), 32'(rst_count));
	endtask
	task automatic ev(input string n, input logic [6:0] x);
		repeat (6) @(posedge clk);
		chk(n, 32'(b + 1), 32'(rst_count));
		chk(n, {25'h0, x}, {25'h0, last_init});
	endtask
	task automatic pulse_wdt();
		b = rst_count;
		wdt <= 1'b1;
		@(posedge clk);
		wdt <= 1'b0;
	endtask
	////////////////////////////////////////////////////////////////////////
	initial begin
		repeat (100000) @(posedge clk);
		errors++;
		results();
	end
	initial begin
		{rst_n, psel, penable, pwrite, paddr, pwdata} = '0;
		{low, osc, sleep, wdt, wdt_cfg} = '0;
		pin_n = 1'b1;
		level = 8'h66;
		rctrl = 8'h55;
		repeat (8) @(posedge clk);
		rst_n <= 1'b1;
		@(posedge clk);
		rd("filter width", reset_source_pkg::ADDR_FILTER_WIDTH, 32'h1);
		rd("cause flags", reset_source_pkg::ADDR_CAUSE_FLAGS, 32'h0);
		rd("status", reset_source_pkg::ADDR_CORE_STATUS, 32'h0);
		wr(reset_source_pkg::ADDR_FILTER_WIDTH, 32'hFFFFFFFF);
		rd("filter width", reset_source_pkg::ADDR_FILTER_WIDTH, 32'h3);
		begin
			logic [31:0] r;
			logic e;
			bus(1'b0, 8'h20, 32'h0, r, e);
			chk("unmapped error", 32'h1, {31'h0, e});
		end
		for (int c = 0; c < 4; c++) begin
			wr(reset_source_pkg::ADDR_FILTER_WIDTH, 32'(c));
			chk("width code", 32'(c), {30'h0, wcode});
			dip(ticks[c] - 2, 0);
			dip(ticks[c] + 2, 1);
		end
		rd("cause flags", reset_source_pkg::ADDR_CAUSE_FLAGS, 32'h4);
		b = rst_count;
		level <= 8'h12;
		ev("level illegal", reset_source_pkg::INIT_FULL);
		level <= 8'h66;
		b = rst_count;
		rctrl <= 8'h00;
		ev("ctrl illegal", reset_source_pkg::INIT_FULL);
		rctrl <= 8'hAA;
		b = rst_count;
		wdt_cfg <= 1'b1;
		@(posedge clk);
		wdt_cfg <= 1'b0;
		ev("wdt cfg", reset_source_pkg::INIT_FULL);
		rd("cause flags", reset_source_pkg::ADDR_CAUSE_FLAGS, 32'hF);
		wr(reset_source_pkg::ADDR_CAUSE_FLAGS, 32'hB);
		rd("cause clear", reset_source_pkg::ADDR_CAUSE_FLAGS, 32'hB);
		wr(reset_source_pkg::ADDR_CAUSE_FLAGS, 32'hF);
		rd("cause no set", reset_source_pkg::ADDR_CAUSE_FLAGS, 32'hB);
		b = rst_count;
		wr(reset_source_pkg::ADDR_PROG_CTRL_ONE, 32'h54);
		wr(reset_source_pkg::ADDR_PROG_CTRL_ONE, 32'h55);
		ev("prog key", reset_source_pkg::INIT_FULL);
		rd("prog reg", reset_source_pkg::ADDR_PROG_CTRL_ONE, 32'h0);
		pulse_wdt();
		ev("wdt normal", reset_source_pkg::INIT_FULL);
		rd("status", reset_source_pkg::ADDR_CORE_STATUS, 32'h20);
		// Pin reset while awake must leave both status flags alone
		b = rst_count;
		pin_n <= 1'b0;
		repeat (6) @(posedge clk);
		pin_n <= 1'b1;
		ev("pin normal", reset_source_pkg::INIT_FULL);
		rd("status", reset_source_pkg::ADDR_CORE_STATUS, 32'h20);
		sleep <= 1'b1;
		b = rst_count;
		pin_n <= 1'b0;
		repeat (6) @(posedge clk);
		pin_n <= 1'b1;
		ev("pin in sleep", reset_source_pkg::INIT_FULL);
		rd("status", reset_source_pkg::ADDR_CORE_STATUS, 32'h10);
		pulse_wdt();
		// Warm action: only counter and stack cleared, ports and irqs kept
		ev("wdt sleep", reset_source_pkg::INIT_WARM);
		rd("status", reset_source_pkg::ADDR_CORE_STATUS, 32'h30);
		wr(reset_source_pkg::ADDR_FILTER_WIDTH, 32'h0);
		dip(12, 0);
		sleep <= 1'b0;
		chk("irq masked", 32'h0, {31'h0, irq});
		rd("irq status", reset_source_pkg::ADDR_IRQ_STATUS, 32'h7F);
		wr(reset_source_pkg::ADDR_IRQ_MASK, 32'h7F);
		chk("irq raised", 32'h1, {31'h0, irq});
		wr(reset_source_pkg::ADDR_IRQ_STATUS, 32'h01);
		rd("irq status", reset_source_pkg::ADDR_IRQ_STATUS, 32'h7E);
		wr(reset_source_pkg::ADDR_IRQ_MASK, 32'h01);
		chk("irq one masked", 32'h0, {31'h0, irq});
		wr(reset_source_pkg::ADDR_IRQ_STATUS, 32'h7E);
		wr(reset_source_pkg::ADDR_IRQ_MASK, 32'h7F);
		chk("irq cleared", 32'h0, {31'h0, irq});
		results();
	end
endmodule // tb_reset_source_flags_and_init
`default_nettype wire
